// ### ascr_core.v
// Serial configuration, conversion control and readout logic with an AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ascr_defs.vh"

module ascr_core #(
    parameter CONV_CYCLES = `ASCR_CONV_CYCLES,   // Conversion duration in hclk cycles.
    parameter DATA_CYCLES = `ASCR_DATA_CYCLES    // Safe access time in hclk cycles.
) (
    input wire hclk,                  // System clock, 250 MHz.
    input wire hresetn,               // Asynchronous reset, active low.
    input wire hsel,                  // AHB slave select.
    input wire [7:0] haddr,           // AHB byte address, low bits.
    input wire [1:0] htrans,          // AHB transfer type.
    input wire hwrite,                // AHB write flag.
    input wire [2:0] hsize,           // AHB transfer size.
    input wire [31:0] hwdata,         // AHB write data.
    input wire hready,                // AHB bus ready.
    output reg [31:0] hrdata,         // AHB read data.
    output wire hreadyout,            // AHB slave ready, never stalls.
    output wire hresp,                // AHB response, always OKAY.
    input wire conversion_start_select, // Pin: rise starts conversion, low selects.
    input wire serial_clock,          // Pin: serial clock from the host.
    input wire serial_data_in,        // Pin: configuration data from the host.
    output reg serial_result_out,     // Pin: serial result and readback data.
    output reg serial_result_out_oe_n, // Output enable, low while driving.
    input wire [15:0] conv_data,      // Raw code from the converter core.
    output reg conv_active,           // Converter core is converting.
    output reg core_powered,          // Core power, off between conversions.
    output reg int_ref_en,            // Internal reference enabled.
    output reg ref_4v096,             // Internal reference at 4.096 V, else 2.5 V.
    output reg ref_buf_en,            // Internal reference buffer enabled.
    output reg temp_sensor_en,        // Temperature sensor enabled.
    output reg [2:0] mux_incc,        // Input channel configuration.
    output reg [2:0] mux_channel,     // Channel selected for conversion.
    output reg filter_quarter_bw      // One-pole filter at a quarter bandwidth.
);

    // Register of fixed width for the conversion counter.
    localparam CNT_W = 13;
    localparam integer CONV_LAST_I = CONV_CYCLES - 1;   // Last conversion cycle, full width.
    localparam integer DATA_LAST_I = DATA_CYCLES - 1;   // Last safe cycle, full width.
    localparam [CNT_W-1:0] CONV_LAST = CONV_LAST_I[CNT_W-1:0];   // Cut to the counter width.
    localparam [CNT_W-1:0] DATA_LAST = DATA_LAST_I[CNT_W-1:0];   // Cut to the counter width.
    // Serial output frame, enough for a busy bit, the result and readback.
    localparam SR_W = 32;
    // Resting levels of the three synchronised pins.
    localparam [2:0] PIN_IDLE = `ASCR_PIN_IDLE;

    // Reference decode: {internal, 4.096 V, buffer, temperature sensor}.
    function [3:0] ref_decode;
        input [2:0] ref_code;
        begin
            case (ref_code)
                `ASCR_REF_INT_2V5: ref_decode = 4'b1011;
                `ASCR_REF_INT_4V096: ref_decode = 4'b1111;
                `ASCR_REF_EXT_BUF_TEMP: ref_decode = 4'b0011;
                `ASCR_REF_EXT_TEMP: ref_decode = 4'b0001;
                `ASCR_REF_EXT_BUF: ref_decode = 4'b0010;
                `ASCR_REF_EXT: ref_decode = 4'b0000;
                default: ref_decode = 4'b0000;
            endcase
        end
    endfunction

    // Output coding: bipolar modes invert the MSB to give twos complement.
    function [15:0] code_result;
        input [15:0] raw;
        input [2:0] incc;
        begin
            if (incc == `ASCR_INCC_TEMP) begin
                code_result = raw;
            end else if (incc[2:1] == 2'b00 || incc == 3'h2) begin
                code_result = {~raw[15], raw[14:0]};
            end else begin
                code_result = raw;
            end
        end
    endfunction

    // Synchronised pin levels and edges: select, serial clock, data in.
    wire [2:0] pin_raw;
    wire [2:0] pin_lvl;
    wire [2:0] pin_rise;
    wire [2:0] pin_fall;
    assign pin_raw = {serial_data_in, serial_clock, conversion_start_select};

    // One synchroniser per input pin.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            ascr_pin_sync #(.IDLE(PIN_IDLE[gi])) u_sync (
                .hclk(hclk),
                .hresetn(hresetn),
                .pin(pin_raw[gi]),
                .level(pin_lvl[gi]),
                .rise(pin_rise[gi]),
                .fall(pin_fall[gi])
            );
        end
    endgenerate

    wire cnv_rise = pin_rise[0];   // Start of a conversion.
    wire cnv_fall = pin_fall[0];   // Start of a serial access.
    wire sck_rise = pin_rise[1];   // Serial clock rising edge.
    wire sck_fall = pin_fall[1];   // Serial clock falling edge.
    wire din_lvl = pin_lvl[2];     // Data in level.

    // Software-visible state.
    reg [1:0] ctrl_q;                  // Busy mode and link enable.
    reg late_access_q;                 // Sticky: activity after safe time.
    reg [31:0] conv_count_q;           // Completed conversions.
    // Conversion state.
    reg [CNT_W-1:0] conv_cnt_q;        // Cycles into the running conversion.
    reg [`ASCR_CFG_W-1:0] active_cfg_q; // Configuration governing conversions.
    reg [`ASCR_CFG_W-1:0] pending_cfg_q; // Last complete word written.
    reg pending_q;                     // A written word waits for conversion end.
    reg [15:0] result_q;               // Result of the last finished conversion.
    reg [`ASCR_CFG_W-1:0] result_cfg_q; // Configuration that made that result.
    // Serial state.
    reg selected_q;                    // Access window open.
    reg [3:0] in_cnt_q;                // Rising edges counted this access.
    reg [`ASCR_CFG_W-2:0] in_sr_q;     // First thirteen bits of the incoming word.
    reg [SR_W-1:0] out_sr_q;           // Outgoing bits, MSB first.

    // Conversion ends on the last counted cycle.
    wire conv_done = conv_active && (conv_cnt_q == CONV_LAST);
    // Safe window is still open while the count has not passed the data time.
    wire in_safe = conv_active && (conv_cnt_q <= DATA_LAST);
    // Serial activity seen on the pins.
    wire pin_activity = sck_rise | sck_fall | pin_rise[2] | pin_fall[2];
    // The fourteenth rising edge completes a configuration word.
    wire cfg_word_done = selected_q && sck_rise && (in_cnt_q == 4'hd);
    wire [`ASCR_CFG_W-1:0] cfg_word = {in_sr_q, din_lvl};
    // Decoded reference controls of the configuration in force.
    wire [3:0] ref_sel_bits = ref_decode(active_cfg_q[`ASCR_CFG_REF_HI:`ASCR_CFG_REF_LO]);

    // AHB address phase capture.
    reg wr_pend_q;          // A write data phase follows.
    reg [7:0] wr_addr_q;    // Address of that write.
    wire ahb_go = hsel && hready && htrans[1];
    wire wr_strobe = wr_pend_q;
    wire late_clr = wr_strobe && (wr_addr_q == `ASCR_OFS_STATUS) &&
                    hwdata[`ASCR_ST_LATE_ACCESS];

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Capture the address phase of writes for the data phase that follows.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else if (hready) begin
            wr_pend_q <= ahb_go && hwrite && (hsize == 3'h2);
            wr_addr_q <= haddr;
        end
    end

    // Control register written in the data phase.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= `ASCR_CTRL_RESET;
        end else if (wr_strobe && wr_addr_q == `ASCR_OFS_CTRL) begin
            ctrl_q <= hwdata[1:0];
        end
    end

    // Read data is registered in the address phase; unmapped reads return zero.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (ahb_go && !hwrite) begin
            case (haddr)
                `ASCR_OFS_CTRL: hrdata <= {30'h00000000, ctrl_q};
                `ASCR_OFS_STATUS: hrdata <= {26'h0000000, late_access_q, in_safe,
                                             pending_q, selected_q, core_powered,
                                             conv_active};
                `ASCR_OFS_ACTIVE_CFG: hrdata <= {18'h00000, active_cfg_q};
                `ASCR_OFS_PENDING_CFG: hrdata <= {18'h00000, pending_cfg_q};
                `ASCR_OFS_RESULT: hrdata <= {16'h0000, result_q};
                `ASCR_OFS_RESULT_CFG: hrdata <= {18'h00000, result_cfg_q};
                `ASCR_OFS_CONV_COUNT: hrdata <= conv_count_q;
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    // Sticky flag for pin activity between the safe time and conversion end.
    // A new event in the clearing cycle keeps the flag set.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            late_access_q <= 1'b0;
        end else if (conv_active && !in_safe && pin_activity) begin
            late_access_q <= 1'b1;
        end else if (late_clr) begin
            late_access_q <= 1'b0;
        end
    end

    // Conversion sequencer: a select rise starts it, power drops when it ends.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conv_active <= 1'b0;
            core_powered <= 1'b0;
            conv_cnt_q <= {CNT_W{1'b0}};
            conv_count_q <= 32'h00000000;
        end else if (conv_done) begin
            conv_active <= 1'b0;
            core_powered <= 1'b0;
            conv_cnt_q <= {CNT_W{1'b0}};
            conv_count_q <= conv_count_q + 32'h00000001;
        end else if (conv_active) begin
            conv_cnt_q <= conv_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end else if (cnv_rise && ctrl_q[`ASCR_CTRL_LINK_EN]) begin
            conv_active <= 1'b1;
            core_powered <= 1'b1;
            conv_cnt_q <= {CNT_W{1'b0}};
        end
    end

    // Result and configuration update at the end of each conversion.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_cfg_q <= `ASCR_CFG_RESET;
            result_q <= 16'h0000;
            result_cfg_q <= `ASCR_CFG_RESET;
        end else if (conv_done) begin
            result_q <= code_result(conv_data, mux_incc);
            result_cfg_q <= active_cfg_q;
            if (pending_q && pending_cfg_q[`ASCR_CFG_UPDATE]) begin
                active_cfg_q <= pending_cfg_q;
            end
        end
    end

    // Pending word: set by a completed serial write, consumed at conversion end.
    // A word completed in the consuming cycle stays pending for the next one.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pending_q <= 1'b0;
            pending_cfg_q <= `ASCR_CFG_RESET;
        end else if (cfg_word_done) begin
            pending_q <= 1'b1;
            pending_cfg_q <= cfg_word;
        end else if (conv_done) begin
            pending_q <= 1'b0;
        end
    end

    // Access window: open on a select fall, closed by the select level going high.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            selected_q <= 1'b0;
        end else if (pin_lvl[0] || !ctrl_q[`ASCR_CTRL_LINK_EN]) begin
            selected_q <= 1'b0;
        end else if (cnv_fall) begin
            selected_q <= 1'b1;
        end
    end

    // Configuration input shift register on serial clock rising edges.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_cnt_q <= 4'h0;
            in_sr_q <= {(`ASCR_CFG_W-1){1'b0}};
        end else if (cnv_fall) begin
            in_cnt_q <= 4'h0;
        end else if (selected_q && sck_rise && in_cnt_q != 4'he) begin
            in_cnt_q <= in_cnt_q + 4'h1;
            in_sr_q <= {in_sr_q[`ASCR_CFG_W-3:0], din_lvl};
        end
    end

    // Output frame: optional busy bit, result, then readback when enabled.
    reg [SR_W-1:0] frame;
    always @* begin
        frame = {SR_W{1'b0}};
        if (ctrl_q[`ASCR_CTRL_BUSY_MODE]) begin
            // Leading bit shows whether a conversion is still running.
            frame[SR_W-1] = conv_active;
            frame[SR_W-2 -: 16] = result_q;
            if (!active_cfg_q[`ASCR_CFG_RB]) begin
                frame[SR_W-18 -: 14] = result_cfg_q;
            end
        end else begin
            frame[SR_W-1 -: 16] = result_q;
            if (!active_cfg_q[`ASCR_CFG_RB]) begin
                frame[SR_W-17 -: 14] = result_cfg_q;
            end
        end
    end

    // Output shift register: loaded when selected, shifted on falling edges.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_sr_q <= {SR_W{1'b0}};
        end else if (cnv_fall) begin
            out_sr_q <= frame;
        end else if (selected_q && sck_fall) begin
            out_sr_q <= {out_sr_q[SR_W-2:0], 1'b0};
        end
    end

    // Drive the serial output only while the access window is open.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_result_out <= 1'b0;
            serial_result_out_oe_n <= 1'b1;
        end else begin
            serial_result_out <= selected_q ? out_sr_q[SR_W-1] : 1'b0;
            serial_result_out_oe_n <= ~selected_q;
        end
    end

    // Analog control outputs follow the configuration in force.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_ref_en <= 1'b0;
            ref_4v096 <= 1'b0;
            ref_buf_en <= 1'b0;
            temp_sensor_en <= 1'b0;
            mux_incc <= 3'h7;
            mux_channel <= 3'h0;
            filter_quarter_bw <= 1'b0;
        end else begin
            int_ref_en <= ref_sel_bits[3];
            ref_4v096 <= ref_sel_bits[2];
            ref_buf_en <= ref_sel_bits[1];
            // Sensor is on with the internal reference and in the sensor-on codes.
            temp_sensor_en <= ref_sel_bits[0] | ref_sel_bits[3];
            mux_incc <= active_cfg_q[`ASCR_CFG_INCC_HI:`ASCR_CFG_INCC_LO];
            mux_channel <= active_cfg_q[`ASCR_CFG_INX_HI:`ASCR_CFG_INX_LO];
            filter_quarter_bw <= ~active_cfg_q[`ASCR_CFG_BW];
        end
    end

endmodule

`default_nettype wire

// ### ascr_defs.vh
// Constants for the serial configuration and readout block of the multichannel converter.
`ifndef ASCR_DEFS_VH
`define ASCR_DEFS_VH

// Register byte offsets on the AHB-Lite bus.
`define ASCR_OFS_CTRL 8'h00
`define ASCR_OFS_STATUS 8'h04
`define ASCR_OFS_ACTIVE_CFG 8'h08
`define ASCR_OFS_PENDING_CFG 8'h0c
`define ASCR_OFS_RESULT 8'h10
`define ASCR_OFS_RESULT_CFG 8'h14
`define ASCR_OFS_CONV_COUNT 8'h18

// Control register fields.
`define ASCR_CTRL_BUSY_MODE 0
`define ASCR_CTRL_LINK_EN 1
`define ASCR_CTRL_RESET 2'h2

// Status register fields; the sticky flag is cleared by writing one.
`define ASCR_ST_CONVERTING 0
`define ASCR_ST_POWERED 1
`define ASCR_ST_SELECTED 2
`define ASCR_ST_PENDING 3
`define ASCR_ST_SAFE 4
`define ASCR_ST_LATE_ACCESS 5

// Configuration word layout.
`define ASCR_CFG_W 14
`define ASCR_CFG_UPDATE 13
`define ASCR_CFG_INCC_HI 12
`define ASCR_CFG_INCC_LO 10
`define ASCR_CFG_INX_HI 9
`define ASCR_CFG_INX_LO 7
`define ASCR_CFG_BW 6
`define ASCR_CFG_REF_HI 5
`define ASCR_CFG_REF_LO 3
`define ASCR_CFG_SEQ_HI 2
`define ASCR_CFG_SEQ_LO 1
`define ASCR_CFG_RB 0
`define ASCR_CFG_RESET 14'h3fff

// Input channel configuration code for the temperature sensor.
`define ASCR_INCC_TEMP 3'h3

// Reference selection codes.
`define ASCR_REF_INT_2V5 3'h0
`define ASCR_REF_INT_4V096 3'h1
`define ASCR_REF_EXT_BUF_TEMP 3'h2
`define ASCR_REF_EXT_TEMP 3'h3
`define ASCR_REF_EXT_BUF 3'h6
`define ASCR_REF_EXT 3'h7

// Resting levels of the synchronised pins {data in, serial clock, select}; select rests high.
`define ASCR_PIN_IDLE 3'h1

// Result width and serial frame lengths.
`define ASCR_RES_W 16
`define ASCR_CFG_BITS 14

// Timing: conversion time and safe access time in ns, converted to cycles of hclk.
`define ASCR_CLK_NS 4
`define ASCR_CONV_TIME_NS 2200
`define ASCR_DATA_TIME_NS 1200
`define ASCR_CONV_CYCLES (`ASCR_CONV_TIME_NS / `ASCR_CLK_NS)
`define ASCR_DATA_CYCLES (`ASCR_DATA_TIME_NS / `ASCR_CLK_NS)

`endif

// ### ascr_pin_sync.v
// Two-flop synchroniser with edge detection for one pin input.
`timescale 1ns/1ps
`default_nettype none

module ascr_pin_sync #(
    parameter [0:0] IDLE = 1'b0   // Resting level of the pin, loaded at reset.
) (
    input wire hclk,      // System clock.
    input wire hresetn,   // Asynchronous reset, active low.
    input wire pin,       // Raw pin from outside the clock domain.
    output wire level,    // Synchronised level.
    output wire rise,     // One-cycle pulse on a rising edge.
    output wire fall      // One-cycle pulse on a falling edge.
);

    reg meta_q;   // First stage, read only by the second stage.
    reg sync_q;   // Second stage, the safe level.
    reg prev_q;   // Delayed level for edge detection.

    // Shift the pin through two stages, then keep one more for edges.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // Starting at the resting level keeps reset release from faking an edge.
            meta_q <= IDLE;
            sync_q <= IDLE;
            prev_q <= IDLE;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;

endmodule

`default_nettype wire

// ### ascr_core_properties.sv
// Concurrent checks on the pins of the converter interface block.
`timescale 1ns/1ps
`default_nettype none
module ascr_core_properties #(
    parameter CONV_CYCLES = 550 // Conversion length in cycles.
) (
    input wire hclk, // System clock.
    input wire hresetn, // Reset, active low.
    input wire conversion_start_select, // Start and select pin.
    input wire serial_result_out, // Serial data out.
    input wire serial_result_out_oe_n, // Output enable, low active.
    input wire conv_active, // Converting.
    input wire core_powered, // Core power.
    input wire int_ref_en, // Internal reference on.
    input wire ref_4v096, // High reference level.
    input wire temp_sensor_en, // Sensor on.
    input wire [2:0] mux_channel // Converted channel.
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [15:0] len_q; // Cycles seen in the current conversion.
    // Counts conversion cycles so the length can be checked at the end.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) len_q <= 16'h0;
        else len_q <= conv_active ? len_q + 16'h1 : 16'h0;
    end
    AST_POWER_ON: assert property (conv_active |-> core_powered)
        else $error("Core unpowered during a conversion.");
    AST_POWER_OFF: assert property (core_powered |-> conv_active)
        else $error("Core powered while idle.");
    AST_CONV_LEN: assert property ($fell(conv_active) |-> len_q == CONV_CYCLES)
        else $error("Conversion length is wrong.");
    AST_START: assert property ($rose(conversion_start_select) && !conv_active |-> ##[1:6] conv_active)
        else $error("Start edge did not start a conversion.");
    AST_TEMP: assert property (int_ref_en |-> temp_sensor_en)
        else $error("Internal reference on without sensor.");
    AST_CFG_HOLD: assert property (conv_active && $past(conv_active) |-> $stable(mux_channel) && $stable(int_ref_en))
        else $error("Settings changed inside a conversion.");
    AST_OE_ZERO: assert property (serial_result_out_oe_n |-> !serial_result_out)
        else $error("Data out not low outside the window.");
    AST_OE_HIGH: assert property ($rose(conversion_start_select) |-> ##[1:6] serial_result_out_oe_n)
        else $error("Output still driven after deselect.");
    AST_WIN: assert property ($fell(conversion_start_select) |-> ##[1:6] !serial_result_out_oe_n)
        else $error("Window did not open on select.");
    COV_CONV: cover property ($fell(conv_active));
    COV_HIGH_REF: cover property (int_ref_en && ref_4v096);
    COV_EXT_SENSOR: cover property (temp_sensor_en && !int_ref_en);
endmodule
`default_nettype wire

// ### ascr_host_model.sv
// Behavioural serial host that writes a configuration and reads a frame.
`timescale 1ns/1ps
`default_nettype none
module ascr_host_model (
    output var logic conversion_start_select, // Start and select, idle high.
    output var logic serial_clock, // Gated serial clock, idle low.
    output var logic serial_data_in, // Configuration data.
    input wire logic serial_result_out // Data from the block.
);
    // The clock rests between frames so stray edges never write the word.
    initial begin
        conversion_start_select = 1'b1;
        serial_clock = 1'b0;
        serial_data_in = 1'b0;
    end
    // One frame of n clocks at 64 ns; the rising select edge ends it.
    task automatic xfer(input logic [13:0] cfg, input int n, output logic [31:0] rx);
        rx = 32'h0;
        conversion_start_select = 1'b0;
        #64;
        for (int i = 0; i < n; i++) begin
            serial_data_in = (i < 14) ? cfg[13 - i] : 1'b0;
            #32 serial_clock = 1'b1;
            rx = {rx[30:0], serial_result_out};
            #32 serial_clock = 1'b0;
        end
        // Pins stay quiet around the start edge.
        #64 conversion_start_select = 1'b1;
    endtask
endmodule
`default_nettype wire

// ### tb.sv
// Testbench for the converter interface block with its serial host.
`timescale 1ns/1ps
`default_nettype none
`include "ascr_defs.vh"
module tb;
    localparam int CONV = 40; // Shortened conversion length.
    logic hclk = 1'b0; // System clock.
    logic hresetn = 1'b0; // Reset, active low.
    logic hsel = 1'b0, hwrite = 1'b0; // Bus select and direction.
    logic [7:0] haddr = 8'h0; // Bus address.
    logic [1:0] htrans = 2'h0; // Transfer type.
    logic [2:0] hsize = 3'h2; // Always a whole word.
    logic [31:0] hwdata = 32'h0; // Write data.
    logic [15:0] conv_data = 16'h0; // Raw code from the core.
    wire [31:0] hrdata; // Read data.
    wire hreadyout, hresp, serial_result_out, serial_result_out_oe_n; // Outputs.
    wire conv_active, core_powered, int_ref_en, ref_4v096; // Core controls.
    wire ref_buf_en, temp_sensor_en, filter_quarter_bw; // Core controls.
    wire [2:0] mux_incc, mux_channel; // Input selection.
    wire conversion_start_select, serial_clock, serial_data_in; // Host pins.
    wire hready = hreadyout; // Single slave drives the bus ready.
    wire link_sdo = serial_result_out_oe_n ? 1'bz : serial_result_out; // Pin level.
    int error_cnt = 0, checked = 0; // Mismatches and comparisons.
    ascr_core #(.CONV_CYCLES(CONV), .DATA_CYCLES(20)) ascr_core_i (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .conversion_start_select, .serial_clock,
        .serial_data_in, .serial_result_out, .serial_result_out_oe_n, .conv_data,
        .conv_active, .core_powered, .int_ref_en, .ref_4v096, .ref_buf_en,
        .temp_sensor_en, .mux_incc, .mux_channel, .filter_quarter_bw);
    ascr_host_model ascr_host_model_i (.conversion_start_select, .serial_clock,
        .serial_data_in, .serial_result_out(link_sdo));
    // Free-running 250 MHz clock.
    always #2 hclk = ~hclk;
    // Compares and counts; reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Prints the verdict and ends the run.
    task automatic close_out;
        if (error_cnt == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // One single AHB transfer; read data is taken at the end of the data phase.
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    // Frame, then a full conversion with the given raw code.
    task automatic conv(input logic [13:0] cfg, input int n, input logic [15:0] raw,
                        output logic [31:0] rx);
        ascr_host_model_i.xfer(cfg, n, rx);
        @(posedge hclk);
        conv_data <= raw;
        repeat (8) @(posedge hclk);
        chk(conv_active, 1'b1);
        chk(core_powered, 1'b1);
        // The next frame waits for the end of this conversion.
        repeat (CONV) @(posedge hclk);
        chk(conv_active, 1'b0);
        chk(core_powered, 1'b0);
    endtask
    // Reset state of pins and the configuration word, plus an unmapped read.
    task automatic t_reset;
        logic [31:0] r;
        chk(serial_result_out_oe_n, 1'b1);
        chk(mux_incc, 3'h7);
        ahb(1'b0, `ASCR_OFS_ACTIVE_CFG, 32'h0, r);
        chk(r, `ASCR_CFG_RESET);
        ahb(1'b0, 8'h1c, 32'h0, r);
        chk(r, 32'h0);
    endtask
    // Every reference code; entries are {code, expected, mask} on int, 4v, buf, sensor.
    task automatic t_refs;
        logic [10:0] tbl [6] = '{11'h09d, 11'h1dd, 11'h233, 11'h313, 11'h623, 11'h70f};
        logic [13:0] cfg;
        logic [31:0] rx, r;
        logic [15:0] prev;
        prev = 16'h0;
        for (int i = 0; i < 6; i++) begin
            // Sensor channels are only used with the internal reference on.
            cfg = {1'b1, (i < 2) ? 3'h3 : 3'h7, 3'(i), 1'b0, tbl[i][10:8], 3'h0};
            conv(cfg, 30, 16'hc000 + 16'(i), rx);
            chk(rx[29:14], prev);
            prev = 16'hc000 + 16'(i);
            chk({int_ref_en, ref_4v096, ref_buf_en, temp_sensor_en} & tbl[i][3:0], tbl[i][7:4]);
            // A clear bandwidth bit selects the quarter-bandwidth filter.
            chk({mux_incc, mux_channel, filter_quarter_bw}, {cfg[12:7], ~cfg[6]});
            ahb(1'b0, `ASCR_OFS_ACTIVE_CFG, 32'h0, r);
            chk(r, {18'h0, cfg});
        end
    endtask
    // Busy mode frame with readback of the word that produced the result.
    task automatic t_busy;
        logic [13:0] cfg;
        logic [31:0] rx, r;
        cfg = {1'b1, 3'h2, 3'h5, 1'b0, 3'h7, 3'h0};
        conv(cfg, 30, 16'h5a3c, rx);
        ahb(1'b1, `ASCR_OFS_CTRL, 32'h3, r);
        conv(cfg, 31, 16'h1234, rx);
        // That result was made under the last word of the reference sweep.
        chk(rx[30:0], {1'b0, 16'h5a3c, 1'b1, 3'h7, 3'h5, 1'b0, 3'h7, 3'h0});
        conv(cfg, 31, 16'h0000, rx);
        // A bipolar input reads out in twos complement, so the MSB flips.
        chk(rx[30:0], {1'b0, 16'h9234, cfg});
        ahb(1'b0, `ASCR_OFS_CONV_COUNT, 32'h0, r);
        chk(r, 32'h9);
    endtask
    // Main sequence after five cycles of reset.
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_refs();
        t_busy();
        close_out();
    end
    // Cuts a hang short well beyond the expected run length.
    initial begin
        #100000;
        error_cnt++;
        close_out();
    end
endmodule
bind ascr_core ascr_core_properties #(.CONV_CYCLES(CONV_CYCLES)) ascr_core_properties_i (
    .hclk, .hresetn, .conversion_start_select, .serial_result_out,
    .serial_result_out_oe_n, .conv_active, .core_powered, .int_ref_en, .ref_4v096,
    .temp_sensor_en, .mux_channel);
`default_nettype wire
